//--- include/adc_resolution_oversampling_map.vh
// Register map, field positions, reset values and timing counts of the converter control block
`ifndef ADC_RESOLUTION_OVERSAMPLING_MAP_VH
`define ADC_RESOLUTION_OVERSAMPLING_MAP_VH

// ==========================================================================
// Register offsets (byte addresses, one 32-bit word each)
`define OFS_CONTROL 6'h00
`define OFS_OVS_CTRL 6'h04
`define OFS_SAMPLE_TIME 6'h08
`define OFS_RESULT 6'h0C
`define OFS_STATUS 6'h10

// ==========================================================================
// Control register fields
`define CTL_ON_BIT 0
`define CTL_SREF_BIT 1
`define CTL_OVS_EN_BIT 2
`define CTL_START_BIT 3
`define CTL_CH_LSB 8
`define CTL_CH_MSB 12

// Oversample control register fields
`define OVS_RATIO_LSB 0
`define OVS_RATIO_MSB 2
`define OVS_SHIFT_LSB 4
`define OVS_SHIFT_MSB 7
`define OVS_RES_LSB 8
`define OVS_RES_MSB 9

// Status register fields
`define STS_DONE_BIT 0
`define STS_BUSY_BIT 1
`define STS_SHORT_BIT 2

// ==========================================================================
// Reset values
`define RST_CONTROL 32'h0000_0000
`define RST_OVS_CTRL 32'h0000_0000
`define RST_SAMPLE_TIME 10'h000

// ==========================================================================
// Channels and resolution codes
`define SENSOR_CH 5'h10
`define BANDGAP_CH 5'h11
`define RES_12 2'h0
`define RES_10 2'h1
`define RES_8 2'h2
`define RES_6 2'h3

// ==========================================================================
// Timing: 1.5 sampling cycles and n.5 approximation cycles are realised as
// whole cycles so that each conversion totals sampling plus approximation
`define SAMPLE_MIN_CYC 10'h001
`define APPROX_12_CYC 10'h00D
`define APPROX_10_CYC 10'h00B
`define APPROX_8_CYC 10'h009
`define APPROX_6_CYC 10'h007
`define MAX_SHIFT 4'h8
`define CLK_PERIOD_NS 20
`define SENSOR_SAMPLE_NS 17100
`define SENSOR_SAMPLE_CYC ((`SENSOR_SAMPLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- logic/adc_resolution_oversampling.v
// Converter sequencing, resolution timing and oversampling accumulator with a Wishbone slave
// Notes on behaviour
// - Enable bit enables sensor and reference channels
// - Cleared enable bit powers the sensor down
// - Bandgap reference drives input channel seventeen
// - Four resolutions: 12, 10, 8, 6 bits
// - Approximation lasts resolution plus half cycle; the logic counts resolution plus one whole cycle (13 at 12 bits)
// - Conversion is sampling plus approximation, 14 minimum at 12 bits, 8 at 6 bits
// - Accumulate N conversions, N from 2 to 256
// - Sum shifts right by 0 to 8 bits
// - 20-bit accumulator, result keeps 16 LSBs
// - Round by adding most significant discarded bit
// - Overflow past 16 bits truncates, no saturation
// - All-0xFFF inputs give 0xFFF0 and 0xFFE0 cases
// - Oversampled conversions keep standard mode timing
// - One result after every N conversions
`timescale 1ns/1ps
`include "adc_resolution_oversampling_map.vh"

module adc_resolution_oversampling #(
   parameter ACC_W = 20,
   parameter RES_W = 16
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Wishbone classic slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [5:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Analog front end
   input wire [11:0] adc_data_i,
   output reg [4:0] channel_o,
   output reg sample_o,
   output reg sensor_power_o,
   output reg sensor_input_channel_o,
   output reg reference_input_channel_o,
   output reg internal_bandgap_ref_o,
   // Result strobe
   output reg [15:0] result_o,
   output reg result_valid_o
);

   // ==========================================================================
   // State encoding
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_SAMPLE = 4'b0010;
   localparam [3:0] ST_APPROX = 4'b0100;
   localparam [3:0] ST_FINISH = 4'b1000;

   // ==========================================================================
   // Register storage
   reg [31:0] control_q;
   reg [31:0] oversample_control_reg_q;
   reg [9:0] sample_time_q;
   reg done_q;
   reg short_q;
   reg [3:0] state_q;
   reg [3:0] state_d;
   reg [9:0] cnt_q;
   reg [9:0] cnt_d;
   reg [8:0] conv_left_q;
   reg [8:0] conv_left_d;
   reg [ACC_W-1:0] acc_q;
   reg [ACC_W-1:0] acc_d;
   reg [1:0] res_run_q;
   reg [2:0] ratio_run_q;
   reg [3:0] shift_run_q;
   reg ovs_run_q;
   reg [4:0] ch_run_q;
   reg [9:0] samp_run_q;

   wire bus_req;
   wire bus_wr;
   wire converter_on;
   wire sensor_ref_enable;
   wire oversample_en;
   wire start_req;
   wire [4:0] channel_sel;
   wire [2:0] oversample_ratio;
   wire [3:0] oversample_shift;
   wire [1:0] resolution_select;

   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // Writes land at the edge where the master samples ack, never before
   assign bus_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
   assign converter_on = control_q[`CTL_ON_BIT];
   assign sensor_ref_enable = control_q[`CTL_SREF_BIT];
   assign oversample_en = control_q[`CTL_OVS_EN_BIT];
   assign channel_sel = control_q[`CTL_CH_MSB:`CTL_CH_LSB];
   assign oversample_ratio = oversample_control_reg_q[`OVS_RATIO_MSB:`OVS_RATIO_LSB];
   assign oversample_shift = oversample_control_reg_q[`OVS_SHIFT_MSB:`OVS_SHIFT_LSB];
   assign resolution_select = oversample_control_reg_q[`OVS_RES_MSB:`OVS_RES_LSB];
   // Start is a write-only strobe; it never stores
   assign start_req = bus_wr & (wb_adr_i == `OFS_CONTROL) & wb_sel_i[0]
                      & wb_dat_i[`CTL_START_BIT] & converter_on;

   // ==========================================================================
   // Resolution dependent data shaping and timing
   function [9:0] approx_cycles;
      input [1:0] res;
      begin
         case (res)
            `RES_12: approx_cycles = `APPROX_12_CYC;
            `RES_10: approx_cycles = `APPROX_10_CYC;
            `RES_8: approx_cycles = `APPROX_8_CYC;
            default: approx_cycles = `APPROX_6_CYC;
         endcase
      end
   endfunction

   // Lower resolutions keep the upper bits of the array, right aligned
   function [11:0] raw_value;
      input [1:0] res;
      input [11:0] d;
      begin
         case (res)
            `RES_12: raw_value = d;
            `RES_10: raw_value = {2'h0, d[11:2]};
            `RES_8: raw_value = {4'h0, d[11:4]};
            default: raw_value = {6'h0, d[11:6]};
         endcase
      end
   endfunction

   // ==========================================================================
   // Shift, round and truncate of the accumulated sum
   reg [3:0] shift_eff;
   reg [ACC_W-1:0] shifted;
   reg round_bit;
   reg [ACC_W:0] rounded;
   reg [15:0] final_value;

   always @* begin
      shift_eff = (shift_run_q > `MAX_SHIFT) ? `MAX_SHIFT : shift_run_q;
      shifted = acc_d >> shift_eff;
      round_bit = (shift_eff == 4'h0) ? 1'b0 : acc_d[shift_eff - 4'h1];
      rounded = {1'b0, shifted} + {{ACC_W{1'b0}}, round_bit};
      final_value = rounded[RES_W-1:0];
   end

   // ==========================================================================
   // Conversion sequencer
   reg [ACC_W-1:0] sample_ext;
   reg last_conv;

   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      conv_left_d = conv_left_q;
      acc_d = acc_q;
      sample_ext = {{(ACC_W-12){1'b0}}, raw_value(res_run_q, adc_data_i)};
      last_conv = (conv_left_q == 9'h001);
      case (state_q)
         ST_IDLE: begin
            if (start_req) begin
               state_d = ST_SAMPLE;
               cnt_d = sample_time_q + `SAMPLE_MIN_CYC;
               acc_d = {ACC_W{1'b0}};
               conv_left_d = oversample_en ? (9'h002 << oversample_control_reg_q[`OVS_RATIO_MSB:0]) : 9'h001;
            end
         end
         ST_SAMPLE: begin
            if (cnt_q == 10'h001) begin
               state_d = ST_APPROX;
               cnt_d = approx_cycles(res_run_q);
            end else begin
               cnt_d = cnt_q - 10'h001;
            end
         end
         ST_APPROX: begin
            if (cnt_q == 10'h001) begin
               acc_d = acc_q + sample_ext;
               conv_left_d = conv_left_q - 9'h001;
               if (last_conv) begin
                  state_d = ST_FINISH;
               end else begin
                  // Same sampling and approximation on every pass
                  state_d = ST_SAMPLE;
                  cnt_d = samp_run_q + `SAMPLE_MIN_CYC;
               end
            end else begin
               cnt_d = cnt_q - 10'h001;
            end
         end
         ST_FINISH: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      // Switching off abandons any sequence in progress
      if (!converter_on) begin
         state_d = ST_IDLE;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         cnt_q <= 10'h000;
         conv_left_q <= 9'h000;
         acc_q <= {ACC_W{1'b0}};
         res_run_q <= `RES_12;
         ratio_run_q <= 3'h0;
         shift_run_q <= 4'h0;
         ovs_run_q <= 1'b0;
         ch_run_q <= 5'h00;
         samp_run_q <= 10'h000;
         result_o <= 16'h0000;
         result_valid_o <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         conv_left_q <= conv_left_d;
         acc_q <= acc_d;
         result_valid_o <= 1'b0;
         if (state_q == ST_IDLE && start_req) begin
            // Settings are frozen per sequence so a late write cannot split it
            res_run_q <= resolution_select;
            ratio_run_q <= oversample_ratio;
            shift_run_q <= oversample_en ? oversample_shift : 4'h0;
            ovs_run_q <= oversample_en;
            ch_run_q <= channel_sel;
            samp_run_q <= sample_time_q;
         end
         if (state_q == ST_APPROX && state_d == ST_FINISH) begin
            result_o <= ovs_run_q ? final_value : acc_d[15:0];
            result_valid_o <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // Analog control outputs
   always @(posedge clk_i) begin
      if (rst_i) begin
         channel_o <= 5'h00;
         sample_o <= 1'b0;
         sensor_power_o <= 1'b0;
         sensor_input_channel_o <= 1'b0;
         reference_input_channel_o <= 1'b0;
         internal_bandgap_ref_o <= 1'b0;
      end else begin
         channel_o <= (state_q == ST_IDLE) ? channel_sel : ch_run_q;
         sample_o <= (state_d == ST_SAMPLE);
         sensor_power_o <= sensor_ref_enable;
         sensor_input_channel_o <= sensor_ref_enable;
         reference_input_channel_o <= sensor_ref_enable;
         // Bandgap is switched onto the input while the sensor/reference enable is set and channel 17 is selected
         internal_bandgap_ref_o <= sensor_ref_enable & (channel_o == `BANDGAP_CH);
      end
   end

   // ==========================================================================
   // Wishbone register file
   reg [31:0] rd_data;

   always @* begin
      rd_data = 32'h0000_0000;
      case (wb_adr_i)
         `OFS_CONTROL: begin
            rd_data = control_q;
            rd_data[`CTL_START_BIT] = 1'b0;
         end
         `OFS_OVS_CTRL: rd_data = oversample_control_reg_q;
         `OFS_SAMPLE_TIME: rd_data = {22'h000000, sample_time_q};
         `OFS_RESULT: rd_data = {16'h0000, result_o};
         `OFS_STATUS: begin
            rd_data[`STS_DONE_BIT] = done_q;
            rd_data[`STS_BUSY_BIT] = (state_q != ST_IDLE);
            rd_data[`STS_SHORT_BIT] = short_q;
         end
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // Sensor conversion with too short a sampling window
   wire short_evt;
   assign short_evt = start_req & (channel_sel == `SENSOR_CH)
                      & ({21'h000000, {1'b0, sample_time_q} + 11'h001} < `SENSOR_SAMPLE_CYC);

   wire clr_wr;
   assign clr_wr = bus_wr & (wb_adr_i == `OFS_STATUS) & wb_sel_i[0];

   always @(posedge clk_i) begin
      if (rst_i) begin
         control_q <= `RST_CONTROL;
         oversample_control_reg_q <= `RST_OVS_CTRL;
         sample_time_q <= `RST_SAMPLE_TIME;
         done_q <= 1'b0;
         short_q <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req) begin
            wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_data;
         end
         if (bus_wr && wb_adr_i == `OFS_CONTROL) begin
            if (wb_sel_i[0]) begin
               control_q[7:0] <= {5'h00, wb_dat_i[2:0]};
            end
            if (wb_sel_i[1]) begin
               control_q[15:8] <= {3'h0, wb_dat_i[12:8]};
            end
         end
         if (bus_wr && wb_adr_i == `OFS_OVS_CTRL) begin
            if (wb_sel_i[0]) begin
               oversample_control_reg_q[7:0] <= {wb_dat_i[7:4], 1'b0, wb_dat_i[2:0]};
            end
            if (wb_sel_i[1]) begin
               oversample_control_reg_q[15:8] <= {6'h00, wb_dat_i[9:8]};
            end
         end
         if (bus_wr && wb_adr_i == `OFS_SAMPLE_TIME) begin
            if (wb_sel_i[0]) begin
               sample_time_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               sample_time_q[9:8] <= wb_dat_i[9:8];
            end
         end
         // Write one clears; a new event in the same cycle wins
         if (state_q == ST_APPROX && state_d == ST_FINISH) begin
            done_q <= 1'b1;
         end else if (clr_wr && wb_dat_i[`STS_DONE_BIT]) begin
            done_q <= 1'b0;
         end
         if (short_evt) begin
            short_q <= 1'b1;
         end else if (clr_wr && wb_dat_i[`STS_SHORT_BIT]) begin
            short_q <= 1'b0;
         end
      end
   end

endmodule

//--- tb/adc_front_model.sv
// Behavioural analog array feeding raw codes to the converter control block
`timescale 1ns/1ps
module adc_front_model (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // From block and bench
   input wire sample_i,
   input wire sensor_power_i,
   input wire [4:0] channel_i,
   input wire [11:0] raw_i,
   // Raw code
   output wire [11:0] adc_data_o
);
   reg held_q;
   reg [11:0] junk_q;
   // ==========================================================================
   // Before any sampling the code is meaningless, so it changes every cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         held_q <= 1'b0;
         junk_q <= 12'h5A5;
      end else begin
         if (sample_i) held_q <= 1'b1;
         junk_q <= ~junk_q;
      end
   end
   // A powered-down sensor gives no usable code
   assign adc_data_o = (held_q && !(channel_i == 5'h10 && !sensor_power_i)) ? raw_i : junk_q;
endmodule

//--- tb/adc_ovs_chk.sv
// Port-level checker for the converter control block
`timescale 1ns/1ps
module adc_ovs_chk #(
   parameter ACC_W = 20,
   parameter RES_W = 16
) (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire [4:0] channel_o,
   input wire sample_o,
   input wire sensor_power_o,
   input wire sensor_input_channel_o,
   input wire reference_input_channel_o,
   input wire internal_bandgap_ref_o,
   input wire [15:0] result_o,
   input wire result_valid_o
);
   // ==========================================================================
   // Properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_pulse_a: // bus
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   ack_latency_a: // bus
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
   sensor_tied_a:
      assert property (sensor_power_o == sensor_input_channel_o && sensor_power_o == reference_input_channel_o)
         else $error("sensor enables disagree");
   bandgap_chan_a:
      assert property (internal_bandgap_ref_o |-> reference_input_channel_o && $past(channel_o) == 5'h11)
         else $error("bandgap on wrong channel");
   valid_pulse_a:
      assert property (result_valid_o |=> !result_valid_o) else $error("result strobe too long");
   result_hold_a:
      assert property (!result_valid_o |-> $stable(result_o)) else $error("result moved without strobe");
   conv_min_a:
      assert property ($rose(sample_o) |-> !result_valid_o [*6]) else $error("conversion too short");
   valid_idle_a:
      assert property (result_valid_o |-> !sample_o) else $error("result while sampling");
   cover property (result_valid_o);
   cover property (internal_bandgap_ref_o);
   cover property ($fell(sensor_power_o));
endmodule

bind adc_resolution_oversampling adc_ovs_chk #(.ACC_W(ACC_W), .RES_W(RES_W)) adc_ovs_chk_i (.clk_i(clk_i),
   .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .channel_o(channel_o),
   .sample_o(sample_o), .sensor_power_o(sensor_power_o), .sensor_input_channel_o(sensor_input_channel_o),
   .reference_input_channel_o(reference_input_channel_o), .internal_bandgap_ref_o(internal_bandgap_ref_o),
   .result_o(result_o), .result_valid_o(result_valid_o));

//--- tb/tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adc_resolution_oversampling_map.vh"
module tb;
   // ==========================================================================
   // Signals
   reg clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg wb_cyc_i = 1'b0;
   reg wb_stb_i = 1'b0;
   reg wb_we_i = 1'b0;
   reg [5:0] wb_adr_i = 6'h00;
   reg [3:0] wb_sel_i = 4'h3;
   reg [31:0] wb_dat_i = 32'h0;
   reg [11:0] raw = 12'h000;
   wire [31:0] wb_dat_o;
   wire [11:0] adc_data;
   wire [15:0] result_o;
   wire [4:0] channel_o;
   wire wb_ack_o, sample_o, sensor_power_o, sensor_input_channel_o;
   wire reference_input_channel_o, internal_bandgap_ref_o, result_valid_o;
   reg [31:0] d;
   integer errors = 0;
   integer comparisons = 0;
   integer i;
   initial forever #10 clk_i = ~clk_i;
   adc_resolution_oversampling adc_resolution_oversampling_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_data_i(adc_data), .channel_o(channel_o), .sample_o(sample_o),
      .sensor_power_o(sensor_power_o), .sensor_input_channel_o(sensor_input_channel_o),
      .reference_input_channel_o(reference_input_channel_o), .internal_bandgap_ref_o(internal_bandgap_ref_o),
      .result_o(result_o), .result_valid_o(result_valid_o));
   adc_front_model adc_front_model_i (.clk_i(clk_i), .rst_i(rst_i), .sample_i(sample_o),
      .sensor_power_i(sensor_power_o), .channel_i(channel_o), .raw_i(raw), .adc_data_o(adc_data));
   // ==========================================================================
   // Shared tasks
   task final_report;
      begin
         $display("errors=%0d comparisons=%0d", errors, comparisons);
         if (errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
         end else begin
            $display("STATUS NOT OK");
         end
         $finish;
      end
   endtask
   task check(input [31:0] got, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // Classic single cycle; the request stands until ack is sampled
   task wb(input we, input [5:0] adr, input [31:0] dat, output [31:0] rd);
      integer n;
      begin
         @(posedge clk_i);
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= we;
         wb_adr_i <= adr;
         wb_dat_i <= dat;
         n = 0;
         do begin
            @(posedge clk_i);
            n = n + 1;
         end while (wb_ack_o !== 1'b1 && n < 50);
         if (wb_ack_o !== 1'b1) begin
            errors = errors + 1;
            final_report;
         end
         rd = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
      end
   endtask
   // One conversion sequence; the resolution is only changed while the converter is off
   task conv(input [1:0] res, input [2:0] ratio, input [3:0] sh, input ovs, input [9:0] s, input [11:0] r);
      reg [19:0] sum;
      reg [31:0] e;
      integer n, want, a, nn;
      begin
         raw <= r;
         wb(1'b1, `OFS_CONTROL, 32'h0, d);
         wb(1'b1, `OFS_OVS_CTRL, {22'h0, res, sh, 1'b0, ratio}, d);
         wb(1'b1, `OFS_SAMPLE_TIME, {22'h0, s}, d);
         wb(1'b1, `OFS_CONTROL, 32'h1 | (ovs << 2), d);
         wb(1'b1, `OFS_STATUS, 32'h1, d);
         wb(1'b1, `OFS_CONTROL, 32'h9 | (ovs << 2), d);
         a = (res == `RES_12) ? `APPROX_12_CYC : (res == `RES_10) ? `APPROX_10_CYC :
            (res == `RES_8) ? `APPROX_8_CYC : `APPROX_6_CYC;
         nn = ovs ? (2 << ratio) : 1;
         // Start lands at the ack edge; the strobe is seen one edge after it is launched
         want = nn * (s + 1 + a) + 1;
         sum = nn * r;
         e = ovs ? ((sum >> sh) + ((sh == 4'h0) ? 20'h0 : sum[sh - 1])) : (r >> (2 * res));
         n = 0;
         while (result_valid_o !== 1'b1 && n < 5000) begin
            @(posedge clk_i);
            n = n + 1;
         end
         if (n >= 5000) begin
            errors = errors + 1;
            final_report;
         end
         check(n, want);
         check(result_o, e[15:0]);
         wb(1'b0, `OFS_RESULT, 32'h0, d);
         check(d[15:0], e[15:0]);
         wb(1'b0, `OFS_STATUS, 32'h0, d);
         check(d[`STS_DONE_BIT], 1'b1);
      end
   endtask
   // Sensor channel: a window under 17.1 us raises the short flag, a long enough one does not
   task sensor_conv(input [9:0] s, input exp_short);
      integer n;
      begin
         raw <= 12'h123;
         wb(1'b1, `OFS_CONTROL, 32'h0, d);
         wb(1'b1, `OFS_OVS_CTRL, 32'h0, d);
         wb(1'b1, `OFS_SAMPLE_TIME, {22'h0, s}, d);
         wb(1'b1, `OFS_CONTROL, 32'h1003, d);
         wb(1'b1, `OFS_STATUS, 32'h5, d);
         wb(1'b1, `OFS_CONTROL, 32'h100B, d);
         n = 0;
         while (result_valid_o !== 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n = n + 1;
         end
         if (n >= 2000) begin
            errors = errors + 1;
            final_report;
         end
         check(result_o, 32'h123);
         wb(1'b0, `OFS_STATUS, 32'h0, d);
         check(d[`STS_SHORT_BIT], exp_short);
      end
   endtask
   // ==========================================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      check({result_o, result_valid_o, sensor_power_o, internal_bandgap_ref_o}, 32'h0);
      wb(1'b0, `OFS_CONTROL, 32'h0, d);
      check(d, `RST_CONTROL);
      wb(1'b0, `OFS_OVS_CTRL, 32'h0, d);
      check(d, `RST_OVS_CTRL);
      wb(1'b1, 6'h3C, 32'hFFFF_FFFF, d);
      wb(1'b0, 6'h3C, 32'h0, d);
      check(d, 32'h0);
      // Three edges: outputs are registered and the bandgap flag trails the channel
      wb(1'b1, `OFS_CONTROL, 32'h1102, d);
      repeat (3) @(posedge clk_i);
      check({sensor_power_o, sensor_input_channel_o, reference_input_channel_o, internal_bandgap_ref_o, channel_o},
         {4'hF, `BANDGAP_CH});
      wb(1'b1, `OFS_CONTROL, 32'h1100, d);
      repeat (2) @(posedge clk_i);
      check({sensor_power_o, sensor_input_channel_o, reference_input_channel_o, internal_bandgap_ref_o}, 4'h0);
      for (i = 0; i < 4; i = i + 1) conv(i[1:0], 3'h0, 4'h0, 1'b0, 10'h000, 12'hABC);
      conv(`RES_12, 3'h7, 4'h4, 1'b1, 10'h000, 12'hFFF);
      conv(`RES_12, 3'h4, 4'h0, 1'b1, 10'h002, 12'hFFF);
      conv(`RES_12, 3'h0, 4'h2, 1'b1, 10'h000, 12'h003);
      conv(`RES_12, 3'h1, `MAX_SHIFT, 1'b1, 10'h000, 12'h0FF);
      sensor_conv(10'h355, 1'b1);
      sensor_conv(10'h356, 1'b0);
      final_report;
   end
endmodule
